// ==== common/dfps_pkg.sv ====
package dfps_pkg;
   // clock rate and derived timing
   localparam longint CLK_HZ = 125_000_000;
   localparam int IN_LOSS_MS = 1000;  // input loss must persist this long
   localparam int EARTH_MS = 20;  // output hold-off for the start earth check
   localparam int RETRY_UNIT_MS = 100;  // retry wait counts in tenths of a second
   localparam int IN_LOSS_CYC = int'(CLK_HZ / 1000 * IN_LOSS_MS);
   localparam int EARTH_CYC = int'(CLK_HZ / 1000 * EARTH_MS);
   localparam int RETRY_UNIT_CYC = int'(CLK_HZ / 1000 * RETRY_UNIT_MS);
   // output frequency in 0.01 Hz; loss detection needs more than 1 Hz
   localparam logic [15:0] OUT_LOSS_MIN_FREQ = 16'h0064;
   // register byte addresses
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_OSPD = 8'h04;
   localparam logic [7:0] ADDR_MAXF = 8'h08;
   localparam logic [7:0] ADDR_RETRY = 8'h0C;
   localparam logic [7:0] ADDR_CMD = 8'h10;
   localparam logic [7:0] ADDR_STAT = 8'h14;
   localparam logic [7:0] ADDR_EXTD = 8'h18;
   // control, retry, command and status register fields
   localparam int CTRL_OUT_LOSS = 0;
   localparam int CTRL_IN_LOSS = 1;
   localparam int CTRL_EARTH = 2;
   localparam int CTRL_ESAVE_LSB = 4;
   localparam int RETRY_WAIT_LSB = 8;
   localparam int RETRY_LIMIT_LSB = 4;
   localparam int CMD_RESET = 0;
   localparam int CMD_INIT = 1;
   localparam int CMD_PM_INIT = 2;
   localparam int STAT_FIRST_LSB = 4;
   localparam int STAT_STATE_LSB = 8;
   // reset values and special settings
   localparam logic [15:0] OSPD_DISABLE = 16'h270F;  // 9999
   localparam logic [15:0] OSPD_MAX = 16'h0190;  // 400 Hz
   localparam logic [15:0] MAXF_RST = 16'h0078;
   localparam logic [12:0] RETRY_WAIT_RST = 13'h000A;  // 1 s
   localparam logic [12:0] RETRY_WAIT_MAX = 13'h1770;  // 600 s
   localparam logic [3:0] ESAVE_NORMAL = 4'h0;
   localparam logic [3:0] ESAVE_OPTIMUM = 4'h9;
   localparam logic [7:0] PM_PCT = 8'h69;  // 105 %
   localparam logic [7:0] PCT_DIV = 8'h64;
   // protective fault codes
   typedef enum logic [3:0] {
      F_NONE = 4'h0, F_OVERCURRENT = 4'h1, F_OVERVOLT = 4'h2, F_OUT_LOSS = 4'h3, F_IN_LOSS = 4'h4,
      F_EARTH = 4'h5, F_OVERSPEED = 4'h6, F_PARAM = 4'h7, F_INITIATED = 4'h8
   } dfps_fault_t;
   typedef enum logic [2:0] {ST_IDLE, ST_EARTH, ST_RUN, ST_WAIT, ST_TRIP} dfps_state_t;
endpackage

// ==== common/dfps_tmr_if.sv ====
// persistence timer hookup between the supervisor and its timers
interface dfps_tmr_if;
   logic run;  // count while high, clear when low
   logic [31:0] limit;  // cycles until done
   logic done;  // level, held while run stays high
   modport ctl (output run, output limit, input done);
   modport tmr (input run, input limit, output done);
endinterface

// ==== logic/dfps_sync.sv ====
// two-stage synchroniser for pin inputs
module dfps_sync #(
   parameter int WIDTH = 10
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] sync_out
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;  // first stage, read only by second
      logic [WIDTH-1:0] sync;
   } dfps_sync_st_t;
   dfps_sync_st_t q, d;
   // one stage pair per bit
   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      always_comb begin
         d.meta[i] = pin_in[i];
         d.sync[i] = q.meta[i];
      end
   end
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
   assign sync_out = q.sync;
   initial begin
      if (WIDTH < 1) $error("dfps_sync: width must be positive");
   end
endmodule

// ==== logic/dfps_timer.sv ====
// counts cycles of continuous run; done stays up until run drops
module dfps_timer (
   input wire logic ref_clk,
   input wire logic resetn,
   dfps_tmr_if.tmr tif
);
   typedef struct packed {
      logic [31:0] cnt;
      logic done;
   } dfps_tmr_st_t;
   dfps_tmr_st_t q, d;
   // any gap in run restarts the count from zero
   always_comb begin
      d = q;
      if (!tif.run) begin
         d.cnt = '0;
         d.done = 1'b0;
      end else if (!q.done) begin
         d.cnt = q.cnt + 32'h00000001;
         d.done = (d.cnt >= tif.limit);
      end
   end
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
   assign tif.done = q.done;
endmodule

// ==== logic/dfps_supervisor.sv ====
// Function
// - keep only the first fault of retry
// - retry reset keeps thermal and brake data
// - no retry after power-on storage fault
// - unselected fault during wait abandons retry
// - never retry an initiated fault
// - trip on output loss while running
// - output loss enable, reset value one
// - input loss trips after one second
// - input loss enable resets to zero
// - earth check only right after start
// - earth check holds output about 20 ms
// - earth fault trips; enable resets zero
// - overspeed trip above threshold, 9999 disables
// - overspeed only under magnet motor control
// - magnet setup sets threshold max times 105%
// - select nine optimum excitation, zero normal
// - no optimum excitation during power-loss restart
// - retry clears fault, restarts after wait
// - retry signal high throughout retry
// - only selected faults start a retry
//
// Decided for this implementation: the register offsets and register access over APB.
module dfps_supervisor #(
   parameter int IN_LOSS_CYC = dfps_pkg::IN_LOSS_CYC,
   parameter int EARTH_CYC = dfps_pkg::EARTH_CYC,
   parameter int RETRY_UNIT_CYC = dfps_pkg::RETRY_UNIT_CYC
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic out_phase_lost,
   input wire logic in_phase_lost,
   input wire logic earth_detect,
   input wire logic start_req,
   input wire logic dc_brake_on,
   input wire logic param_fault_in,
   input wire logic overcurrent_in,
   input wire logic overvoltage_in,
   input wire logic ipf_restart,
   input wire logic pm_control,
   input wire logic [15:0] out_freq,
   input wire logic [15:0] motor_speed,
   output logic drive_enable,
   output logic trip_out,
   output logic retry_active_signal,
   output logic restart_pulse,
   output logic optimum_excitation,
   output logic thermal_clear,
   output logic [3:0] fault_code
);
   // synchronised pins
   logic [9:0] pins;
   logic s_out_lost, s_in_lost, s_earth, s_start, s_dc, s_pe, s_oc, s_ov, s_ipf, s_pm;
   assign {s_pm, s_ipf, s_ov, s_oc, s_pe, s_dc, s_start, s_earth, s_in_lost, s_out_lost} = pins;
   dfps_sync #(.WIDTH(10)) u_sync (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .pin_in({pm_control, ipf_restart, overvoltage_in, overcurrent_in, param_fault_in, dc_brake_on, start_req,
               earth_detect, in_phase_lost, out_phase_lost}),
      .sync_out(pins)
   );

   typedef struct packed {
      dfps_pkg::dfps_state_t st;
      logic out_loss_en;  // output loss protection
      logic in_loss_en;  // input loss protection
      logic earth_en;  // start earth check
      logic [3:0] esave;  // energy saving selection
      logic [15:0] ospd;  // overspeed threshold, Hz
      logic [15:0] maxf;  // maximum motor frequency, Hz
      logic [2:0] rsel;  // retry fault selection
      logic [3:0] rlimit;  // retries allowed, zero is off
      logic [12:0] rwait;  // retry wait in 0.1 s
      logic [7:0] extd;  // extended display selection
      logic [3:0] rcnt;  // retries used in this sequence
      logic [31:0] unit_cnt;  // cycles inside one 0.1 s
      logic [12:0] tenth_cnt;  // tenths waited
      dfps_pkg::dfps_fault_t fault;
      dfps_pkg::dfps_fault_t first;
      logic boot;  // no start seen yet since power-on
      logic pe_boot;  // storage fault caught at power-on
      logic pm_prev;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic drive;
      logic trip;
      logic retry;
      logic restart;
      logic excite;
      logic thclr;
   } dfps_st_t;
   dfps_st_t q, d;

   // persistence timers
   dfps_tmr_if t_in ();
   dfps_tmr_if t_gf ();
   dfps_timer u_in_tmr (.ref_clk(ref_clk), .resetn(resetn), .tif(t_in));
   dfps_timer u_gf_tmr (.ref_clk(ref_clk), .resetn(resetn), .tif(t_gf));
   assign t_in.run = s_in_lost && q.in_loss_en && (q.st == dfps_pkg::ST_RUN);
   assign t_in.limit = 32'(IN_LOSS_CYC);
   assign t_gf.run = (q.st == dfps_pkg::ST_EARTH);
   assign t_gf.limit = 32'(EARTH_CYC);

   // retry selection table: which faults a setting lets retry
   function automatic logic retry_ok(input logic [2:0] sel, input dfps_pkg::dfps_fault_t f);
      logic oc, ov, wide;
      oc = (f == dfps_pkg::F_OVERCURRENT);
      ov = (f == dfps_pkg::F_OVERVOLT);
      wide = (f == dfps_pkg::F_EARTH) || (f == dfps_pkg::F_PARAM) || (f == dfps_pkg::F_IN_LOSS) ||
             (f == dfps_pkg::F_OVERSPEED);
      case (sel)
         3'h0: retry_ok = oc || ov || wide;
         3'h1: retry_ok = oc;
         3'h2: retry_ok = ov;
         3'h3: retry_ok = oc || ov;
         3'h4: retry_ok = oc || ov || wide;
         3'h5: retry_ok = oc;
         default: retry_ok = 1'b0;
      endcase
   endfunction

   // register address match, shared by read and write paths
   function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
      hit = (a == r);
   endfunction

   // fault sources and priority
   logic running, f_lf, f_os, f_gf, f_oc, f_ov, f_init, wr_go, cmd_reset, cmd_pm;
   logic [23:0] pm_prod;
   dfps_pkg::dfps_fault_t new_fault;
   always_comb begin
      running = (q.st == dfps_pkg::ST_RUN);
      wr_go = psel && penable && q.pready && pwrite;
      f_init = wr_go && hit(paddr, dfps_pkg::ADDR_CMD) && pwdata[dfps_pkg::CMD_INIT];
      cmd_reset = wr_go && hit(paddr, dfps_pkg::ADDR_CMD) && pwdata[dfps_pkg::CMD_RESET];
      cmd_pm = wr_go && hit(paddr, dfps_pkg::ADDR_CMD) && pwdata[dfps_pkg::CMD_PM_INIT];
      f_lf = running && q.out_loss_en && s_out_lost && !s_dc && (out_freq > dfps_pkg::OUT_LOSS_MIN_FREQ);
      f_os = running && s_pm && (q.ospd != dfps_pkg::OSPD_DISABLE) && (motor_speed > q.ospd);
      f_gf = (q.st == dfps_pkg::ST_EARTH) && s_earth;
      f_oc = s_oc && (running || q.st == dfps_pkg::ST_EARTH);
      f_ov = s_ov && (running || q.st == dfps_pkg::ST_EARTH);
      pm_prod = {8'h00, q.maxf} * {16'h0000, dfps_pkg::PM_PCT};
      if (f_init) new_fault = dfps_pkg::F_INITIATED;
      else if (s_pe) new_fault = dfps_pkg::F_PARAM;
      else if (f_gf) new_fault = dfps_pkg::F_EARTH;
      else if (f_oc) new_fault = dfps_pkg::F_OVERCURRENT;
      else if (f_ov) new_fault = dfps_pkg::F_OVERVOLT;
      else if (f_lf) new_fault = dfps_pkg::F_OUT_LOSS;
      else if (t_in.done) new_fault = dfps_pkg::F_IN_LOSS;
      else if (f_os) new_fault = dfps_pkg::F_OVERSPEED;
      else new_fault = dfps_pkg::F_NONE;
   end

   // register file, fault sequencing, outputs
   always_comb begin
      logic can_retry, allow;
      d = q;
      can_retry = 1'b0;
      allow = (q.extd == 8'h00);
      d.thclr = 1'b0;
      d.restart = 1'b0;
      d.pm_prev = s_pm;
      // apb: setup cycle prepares the answer, access cycle completes it
      d.pready = psel && !penable && !q.pready;
      if (psel && !penable && !q.pready) begin
         d.pslverr = 1'b0;
         d.prdata = '0;
         if (hit(paddr, dfps_pkg::ADDR_CTRL)) begin
            d.prdata[dfps_pkg::CTRL_OUT_LOSS] = q.out_loss_en;
            d.prdata[dfps_pkg::CTRL_IN_LOSS] = q.in_loss_en;
            d.prdata[dfps_pkg::CTRL_EARTH] = q.earth_en;
            d.prdata[dfps_pkg::CTRL_ESAVE_LSB +: 4] = q.esave;
         end else if (hit(paddr, dfps_pkg::ADDR_OSPD)) begin
            d.prdata[15:0] = q.ospd;
         end else if (hit(paddr, dfps_pkg::ADDR_MAXF)) begin
            d.prdata[15:0] = q.maxf;
         end else if (hit(paddr, dfps_pkg::ADDR_RETRY)) begin
            d.prdata[2:0] = q.rsel;
            d.prdata[dfps_pkg::RETRY_LIMIT_LSB +: 4] = q.rlimit;
            d.prdata[dfps_pkg::RETRY_WAIT_LSB +: 13] = q.rwait;
         end else if (hit(paddr, dfps_pkg::ADDR_STAT)) begin
            d.prdata[3:0] = q.fault;
            d.prdata[dfps_pkg::STAT_FIRST_LSB +: 4] = q.first;
            d.prdata[dfps_pkg::STAT_STATE_LSB +: 3] = q.st;
         end else if (hit(paddr, dfps_pkg::ADDR_EXTD)) begin
            d.prdata[7:0] = q.extd;
         end else if (!hit(paddr, dfps_pkg::ADDR_CMD)) begin
            // unmapped address
            d.pslverr = 1'b1;
         end
      end
      // settings writes; ignored unless extended display is zero
      if (wr_go && allow) begin
         if (hit(paddr, dfps_pkg::ADDR_CTRL)) begin
            d.out_loss_en = pwdata[dfps_pkg::CTRL_OUT_LOSS];
            d.in_loss_en = pwdata[dfps_pkg::CTRL_IN_LOSS];
            d.earth_en = pwdata[dfps_pkg::CTRL_EARTH];
            // only the two documented selections are taken
            if (pwdata[dfps_pkg::CTRL_ESAVE_LSB +: 4] == dfps_pkg::ESAVE_NORMAL ||
                pwdata[dfps_pkg::CTRL_ESAVE_LSB +: 4] == dfps_pkg::ESAVE_OPTIMUM) begin
               d.esave = pwdata[dfps_pkg::CTRL_ESAVE_LSB +: 4];
            end
         end else if (hit(paddr, dfps_pkg::ADDR_OSPD)) begin
            // out-of-range threshold is ignored
            if (pwdata[15:0] <= dfps_pkg::OSPD_MAX || pwdata[15:0] == dfps_pkg::OSPD_DISABLE) begin
               d.ospd = pwdata[15:0];
            end
         end else if (hit(paddr, dfps_pkg::ADDR_MAXF)) begin
            d.maxf = pwdata[15:0];
         end else if (hit(paddr, dfps_pkg::ADDR_RETRY)) begin
            if (pwdata[2:0] <= 3'h5) d.rsel = pwdata[2:0];
            d.rlimit = pwdata[dfps_pkg::RETRY_LIMIT_LSB +: 4];
            if (pwdata[dfps_pkg::RETRY_WAIT_LSB +: 13] != 13'h0000 &&
                pwdata[dfps_pkg::RETRY_WAIT_LSB +: 13] <= dfps_pkg::RETRY_WAIT_MAX) begin
               d.rwait = pwdata[dfps_pkg::RETRY_WAIT_LSB +: 13];
            end
         end
      end
      if (wr_go && hit(paddr, dfps_pkg::ADDR_EXTD)) d.extd = pwdata[7:0];
      // magnet control selected by setup pin edge or command
      if ((s_pm && !q.pm_prev) || (cmd_pm && allow)) d.ospd = 16'(pm_prod / {16'h0000, dfps_pkg::PCT_DIV});
      // a storage fault before the first start counts as power-on
      if (q.boot && s_pe) d.pe_boot = 1'b1;
      if (s_start) d.boot = 1'b0;
      can_retry = retry_ok(q.rsel, new_fault) && (q.rlimit != 4'h0) && (q.rcnt < q.rlimit) &&
                  (new_fault != dfps_pkg::F_INITIATED) && !(new_fault == dfps_pkg::F_PARAM && (q.pe_boot || q.boot));
      case (q.st)
         dfps_pkg::ST_IDLE, dfps_pkg::ST_EARTH, dfps_pkg::ST_RUN: begin
            if (new_fault != dfps_pkg::F_NONE) begin
               d.fault = new_fault;
               // first fault held across the retry sequence
               if (q.first == dfps_pkg::F_NONE) d.first = new_fault;
               d.unit_cnt = '0;
               d.tenth_cnt = '0;
               if (can_retry) begin
                  d.st = dfps_pkg::ST_WAIT;
                  d.rcnt = q.rcnt + 4'h1;
               end else begin
                  d.st = dfps_pkg::ST_TRIP;
               end
            end else if (q.st == dfps_pkg::ST_IDLE && s_start) begin
               // check on a fresh start from idle; a retry restart checks again
               d.st = q.earth_en ? dfps_pkg::ST_EARTH : dfps_pkg::ST_RUN;
            end else if (q.st == dfps_pkg::ST_EARTH && t_gf.done) begin
               d.st = dfps_pkg::ST_RUN;
            end else if (q.st == dfps_pkg::ST_RUN && !s_start) begin
               d.st = dfps_pkg::ST_IDLE;
            end
         end
         dfps_pkg::ST_WAIT: begin
            if (new_fault != dfps_pkg::F_NONE && !can_retry) begin
               // abandon retry, show the new fault
               d.st = dfps_pkg::ST_TRIP;
               d.fault = new_fault;
            end else if (q.unit_cnt >= 32'(RETRY_UNIT_CYC - 1)) begin
               d.unit_cnt = '0;
               d.tenth_cnt = q.tenth_cnt + 13'h0001;
               // wait over: clear fault, restart from start frequency
               if (d.tenth_cnt >= q.rwait) begin
                  d.fault = dfps_pkg::F_NONE;
                  d.restart = 1'b1;
                  // retry reset leaves thermal data alone
                  d.thclr = 1'b0;
                  d.st = q.earth_en ? dfps_pkg::ST_EARTH : dfps_pkg::ST_RUN;
               end
            end else begin
               d.unit_cnt = q.unit_cnt + 32'h00000001;
            end
         end
         dfps_pkg::ST_TRIP: begin
            // operator reset ends the sequence and rearms retries
            if (cmd_reset) begin
               d.st = dfps_pkg::ST_IDLE;
               d.fault = dfps_pkg::F_NONE;
               d.first = dfps_pkg::F_NONE;
               d.rcnt = '0;
            end
         end
         default: d.st = dfps_pkg::ST_IDLE;
      endcase
      // registered outputs
      d.drive = (d.st == dfps_pkg::ST_RUN);
      d.trip = (d.st == dfps_pkg::ST_TRIP);
      // flag for the whole retry wait
      d.retry = (d.st == dfps_pkg::ST_WAIT);
      d.excite = (q.esave == dfps_pkg::ESAVE_OPTIMUM) && !s_ipf;
   end

   // state register; thermal clear pulses only after power-on
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         q <= '0;
         q.st <= dfps_pkg::ST_IDLE;
         q.out_loss_en <= 1'b1;
         q.ospd <= dfps_pkg::OSPD_DISABLE;
         q.maxf <= dfps_pkg::MAXF_RST;
         q.rwait <= dfps_pkg::RETRY_WAIT_RST;
         q.fault <= dfps_pkg::F_NONE;
         q.first <= dfps_pkg::F_NONE;
         q.boot <= 1'b1;
         q.thclr <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign prdata = q.prdata;
   assign pready = q.pready;
   assign pslverr = q.pslverr;
   assign drive_enable = q.drive;
   assign trip_out = q.trip;
   assign retry_active_signal = q.retry;
   assign restart_pulse = q.restart;
   assign optimum_excitation = q.excite;
   assign thermal_clear = q.thclr;
   assign fault_code = q.fault;

   initial begin
      if (IN_LOSS_CYC < 1 || EARTH_CYC < 1 || RETRY_UNIT_CYC < 2) $error("dfps_supervisor: bad timing count");
   end

   logic can_retry_w;
   assign can_retry_w = retry_ok(q.rsel, new_fault) && (q.rlimit != 4'h0) && (q.rcnt < q.rlimit) &&
                        (new_fault != dfps_pkg::F_INITIATED) && !(new_fault == dfps_pkg::F_PARAM && (q.pe_boot || q.boot));
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   a_loss_trip: assert property ($rose(f_lf) && !f_init && !s_pe && !f_gf && !f_oc && !f_ov |=> fault_code == 4'h3)
      else $error("output loss did not set its fault");
   a_pe_noretry: assert property (q.pe_boot && new_fault == dfps_pkg::F_PARAM |=> !retry_active_signal)
      else $error("retry after power-on storage fault");
   a_init_noretry: assert property (f_init && q.st != dfps_pkg::ST_TRIP |=> trip_out && fault_code == 4'h8)
      else $error("initiated fault did not trip");
   a_earth_hold: assert property ($rose(q.st == dfps_pkg::ST_EARTH) |=> !drive_enable [*8])
      else $error("output released during earth check");
   a_os_gate: assert property (q.st == dfps_pkg::ST_RUN && !s_pm |=> fault_code != 4'h6)
      else $error("overspeed outside magnet control");
   a_excite_off: assert property (s_ipf |=> !optimum_excitation)
      else $error("optimum excitation during restart");
   a_first_kept: assert property (q.first != dfps_pkg::F_NONE && !cmd_reset |=> $stable(q.first))
      else $error("first fault overwritten");
   a_retry_flag: assert property (q.st == dfps_pkg::ST_WAIT |=> retry_active_signal || $past(q.st) != q.st)
      else $error("retry flag dropped during wait");
   a_abandon: assert property (q.st == dfps_pkg::ST_WAIT && new_fault != 4'h0 && !can_retry_w |=> trip_out)
      else $error("unselected fault did not abandon retry");
   a_thclr_por: assert property (restart_pulse |-> !thermal_clear)
      else $error("retry cleared thermal data");
   c_retry_done: cover property (retry_active_signal ##1 restart_pulse);
   c_earth_trip: cover property (f_gf ##1 trip_out);
   c_in_loss: cover property (t_in.done ##1 fault_code == 4'h4);
   c_abandon: cover property (retry_active_signal ##1 trip_out);
endmodule

// ==== test/dfps_stage_model.sv ====
// far side: output stage and fault sensing, driven from the bench's fault wishes
module dfps_stage_model (
   input wire logic ref_clk,
   input wire logic drive_enable,
   input wire logic [5:0] flt,
   input wire logic [15:0] spd,
   output logic [5:0] pins,
   output logic [15:0] out_freq,
   output logic [15:0] motor_speed
);
   timeunit 1ns;
   timeprecision 1ps;
   // sensing reports one cycle late, like a real comparator path
   always @(posedge ref_clk) begin
      pins <= flt;
   end
   // stage runs at 50 hz only while enabled; coasting is not modelled
   assign out_freq = drive_enable ? 16'h1388 : 16'h0000;
   assign motor_speed = drive_enable ? spd : 16'h0000;
endmodule

// ==== test/drive_fault_protection_supervisor_tb_top.sv ====
module drive_fault_protection_supervisor_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, start_req = 0, ipf = 0, pm = 0, brk = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic pready, pslverr, drive_enable, trip_out, retry_on, restart_pulse, opt_ex, rerr, thclr;
   logic [5:0] flt = 6'h00, pins;
   logic [15:0] spd = 16'h0000, out_freq, motor_speed;
   logic [3:0] fault_code;
   int errors = 0, compares = 0, cyc = 0;
   always #4 ref_clk = ~ref_clk;
   dfps_stage_model model_u (.ref_clk(ref_clk), .drive_enable(drive_enable), .flt(flt), .spd(spd), .pins(pins),
      .out_freq(out_freq), .motor_speed(motor_speed));
   dfps_supervisor #(.IN_LOSS_CYC(20), .EARTH_CYC(10), .RETRY_UNIT_CYC(4)) dut_u (.ref_clk(ref_clk),
      .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .out_phase_lost(pins[3]), .in_phase_lost(pins[2]),
      .earth_detect(pins[4]), .start_req(start_req), .dc_brake_on(brk), .param_fault_in(pins[5]),
      .overcurrent_in(pins[0]), .overvoltage_in(pins[1]), .ipf_restart(ipf), .pm_control(pm), .out_freq(out_freq),
      .motor_speed(motor_speed), .drive_enable(drive_enable), .trip_out(trip_out),
      .retry_active_signal(retry_on), .restart_pulse(restart_pulse), .optimum_excitation(opt_ex),
      .thermal_clear(thclr), .fault_code(fault_code));
   task automatic print_verdict;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // hang guard, well above the sum of all scenarios
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         print_verdict;
      end
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         errors++;
         $display("BAD %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   // one apb transfer; request held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1;
      // only the hang guard ends this wait
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      r = prdata;
      rerr = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge ref_clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(0, a, 32'h0);
      chk(r, e);
   endtask
   // bounded wait for a fault code, then judge it
   task automatic waitf(input logic [3:0] e);
      for (int i = 0; i < 200 && fault_code !== e; i++) @(posedge ref_clk);
      chk(32'(fault_code), 32'(e));
   endtask
   // operator fault reset from trip, everything idle again
   task automatic clear;
      start_req <= 0;
      flt <= 6'h00;
      apb(1, 8'h10, 32'h1);
      wt(4);
   endtask
   task automatic t_regs;
      rd(8'h00, 32'h1);
      rd(8'h04, 32'h270F);
      apb(0, 8'h1C, 32'h0);
      chk(32'(rerr), 32'h1);
   endtask
   task automatic t_gate;
      apb(1, 8'h18, 32'h1);
      apb(1, 8'h00, 32'h0);
      rd(8'h00, 32'h1);
      apb(1, 8'h18, 32'h0);
      apb(1, 8'h00, 32'h91);
      wt(3);
      chk(32'(opt_ex), 32'h1);
      ipf <= 1;
      wt(5);
      chk(32'(opt_ex), 32'h0);
      ipf <= 0;
      apb(1, 8'h00, 32'h1);
   endtask
   task automatic t_speed;
      apb(1, 8'h08, 32'h64);
      apb(1, 8'h04, 32'h0);
      apb(1, 8'h10, 32'h4);
      rd(8'h04, 32'h69);
      start_req <= 1;
      spd <= 16'h00C8;
      wt(12);
      chk(32'(fault_code), 32'h0);
      pm <= 1;
      waitf(4'h6);
      chk(32'({trip_out, drive_enable}), 32'h2);
      clear;
      pm <= 0;
      spd <= 16'h0000;
   endtask
   task automatic t_loss;
      apb(1, 8'h00, 32'h3);
      start_req <= 1;
      flt <= 6'h04;
      wt(12);
      chk(32'(fault_code), 32'h0);
      waitf(4'h4);
      clear;
      start_req <= 1;
      flt <= 6'h08;
      waitf(4'h3);
      clear;
   endtask
   task automatic t_earth;
      apb(1, 8'h00, 32'h5);
      start_req <= 1;
      wt(5);
      chk(32'(drive_enable), 32'h0);
      wt(20);
      flt <= 6'h10;
      wt(10);
      chk(32'({fault_code, drive_enable}), 32'h1);
      start_req <= 0;
      wt(4);
      start_req <= 1;
      waitf(4'h5);
      clear;
      apb(1, 8'h00, 32'h1);
   endtask
   // retry on overcurrent, then an initiated fault lands in the wait
   task automatic t_retry;
      apb(1, 8'h0C, 32'hA21);
      start_req <= 1;
      wt(6);
      flt <= 6'h01;
      wt(6);
      flt <= 6'h00;
      chk(32'({retry_on, trip_out}), 32'h2);
      for (int i = 0; i < 80 && restart_pulse !== 1'b1; i++) @(posedge ref_clk);
      chk(32'(restart_pulse), 32'h1);
      chk(32'(thclr), 32'h0);
      wt(6);
      flt <= 6'h01;
      wt(6);
      flt <= 6'h00;
      apb(1, 8'h10, 32'h2);
      waitf(4'h8);
      rd(8'h14, 32'h418);
      clear;
   endtask
   // second power-on: storage fault before any start must not retry
   task automatic t_pe;
      resetn <= 0;
      wt(2);
      chk(32'(thclr), 32'h1);
      resetn <= 1;
      wt(2);
      apb(1, 8'h0C, 32'hA20);
      flt <= 6'h20;
      waitf(4'h7);
      chk(32'({retry_on, trip_out}), 32'h1);
      flt <= 6'h00;
      wt(4);
      clear;
   endtask
   initial begin
      wt(5);
      chk(32'(thclr), 32'h1);
      resetn <= 1;
      wt(1);
      t_regs;
      t_gate;
      t_speed;
      t_loss;
      t_earth;
      t_retry;
      t_pe;
      print_verdict;
   end
endmodule
